// *** rtl/lane_fifo.sv ***
// dual-clock fifo with gray-coded pointers and registered flags
`timescale 1ns/1ps
module lane_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 8
) (
  input  wire logic             wclk,
  input  wire logic             wrst_n,
  input  wire logic             w_valid,
  input  wire logic [WIDTH-1:0] w_data,
  output logic                  w_ready,
  input  wire logic             rclk,
  input  wire logic             rrst_n,
  input  wire logic             r_ready,
  output logic                  r_valid,
  output logic      [WIDTH-1:0] r_data
);
  localparam int AW = $clog2(DEPTH);
  typedef logic [AW:0] ptr_t;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    ptr_t                        bin;
    ptr_t                        gray;
    ptr_t                        rg_s1;
    ptr_t                        rg_s2;
    logic                        ready;
  } wside_t;

  typedef struct packed {
    ptr_t             bin;
    ptr_t             gray;
    ptr_t             wg_s1;
    ptr_t             wg_s2;
    logic             valid;
    logic [WIDTH-1:0] data;
  } rside_t;

  wside_t w_reg, w_next;
  rside_t r_reg, r_next;

  always_comb begin
    w_next = w_reg;
    w_next.rg_s1 = r_reg.gray;
    w_next.rg_s2 = w_reg.rg_s1;
    if (w_valid && w_reg.ready) begin
      w_next.mem[w_reg.bin[AW-1:0]] = w_data;
      w_next.bin = w_reg.bin + 1'b1;
    end
    w_next.gray = w_next.bin ^ (w_next.bin >> 1);
    // full when the write pointer has lapped the synced read pointer
    w_next.ready = w_next.gray != {~w_next.rg_s2[AW:AW-1], w_next.rg_s2[AW-2:0]};
  end

  always_comb begin
    r_next = r_reg;
    r_next.wg_s1 = w_reg.gray;
    r_next.wg_s2 = r_reg.wg_s1;
    if (r_ready && r_reg.valid) begin
      r_next.bin = r_reg.bin + 1'b1;
    end
    r_next.gray = r_next.bin ^ (r_next.bin >> 1);
    r_next.valid = r_next.gray != r_next.wg_s2;
    // entry is stable once its pointer has crossed, so sampling it here is safe
    r_next.data = w_reg.mem[r_next.bin[AW-1:0]];
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      w_reg <= '0;
    end else begin
      w_reg <= w_next;
    end
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign w_ready = w_reg.ready;
  assign r_valid = r_reg.valid;
  assign r_data  = r_reg.data;
endmodule

// *** rtl/quad_lanes.sv ***
// quad-pumped data lanes of the processor side of the system bus
//
// Summary of operation
// [RL1] all 64 data lines are driven together
// [RL2] driver asserts valid flag on every transfer
// [RL3] four beats sent per common bus clock
// [RL4] receiver captures on both strobe falling edges
// [RL5] four 16-bit groups, each with strobe pair
// [RL6] one inversion line per group, same index
// [RL7] active inversion line means active-high data
// [RL8] processor drives three-bit frequency select output
// [RL9] all agents run at one common frequency
// [RL10] invert group when over half bits toggle
// [RL11] valid flag may drop for idle clocks
// [RL12] only the data driver drives strobes, inversion
`timescale 1ns/1ps
`include "quad_lanes_map.svh"
module quad_lanes #(
  parameter logic [`FREQ_SEL_WIDTH-1:0] FREQ_SEL   = `FREQ_SEL_DEFAULT,
  parameter int                         FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        link_clk,
  input  wire logic                        tx_enable,
  input  wire logic                        tx_valid,
  input  wire quad_lanes_pkg::quad_word_t  tx_data,
  output logic                             tx_ready,
  output logic                             rx_valid,
  output quad_lanes_pkg::quad_word_t       rx_data,
  input  wire logic                        rx_ready,
  output logic [`FREQ_SEL_WIDTH-1:0]       bus_freq_select,
  input  wire quad_lanes_pkg::lane_pins_t  pins_in,
  output quad_lanes_pkg::lane_pins_t       pins_out,
  output quad_lanes_pkg::lane_oe_t         pins_oe_n
);
  import quad_lanes_pkg::*;

  localparam int G  = `LANE_GROUPS;
  localparam int GW = `GROUP_WIDTH;
  localparam int DW = `DATA_WIDTH;
  localparam int QW = `QUAD_BEATS * `DATA_WIDTH;

  // ---------------- core clock domain ----------------
  typedef struct packed {
    logic [`FREQ_SEL_WIDTH-1:0] freq_sel;
  } core_state_t;

  core_state_t c_reg, c_next;

  always_comb begin
    c_next = c_reg;
    // [RL8] frequency select drive
    c_next.freq_sel = FREQ_SEL;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= '{freq_sel: FREQ_SEL};
    end else begin
      c_reg <= c_next;
    end
  end

  assign bus_freq_select = c_reg.freq_sel;

  // ---------------- link reset ----------------
  // asynchronous assert, release synchronised to the link clock
  logic [1:0] lrst_sync_reg;
  logic       lrst_n;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_sync_reg <= 2'h0;
    end else begin
      lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
    end
  end

  assign lrst_n = lrst_sync_reg[1];

  // ---------------- link clock domain ----------------
  typedef struct packed {
    logic             en_s1;
    logic             en_s2;
    logic [1:0]       phase;
    logic             driving;
    logic [2:0]       drv_hist;
    quad_word_t       block;
    logic [DW-1:0]    prev_pins;
    lane_pins_t       pins;
    lane_oe_t         oe_n;
    lane_pins_t       in_s1;
    lane_pins_t       in_s2;
    logic [G-1:0]     pos_s3;
    logic [G-1:0]     neg_s3;
    logic [1:0]       rx_cnt;
    quad_word_t       rx_block;
    logic             rx_push;
  } link_state_t;

  // idle bus floats high, so pin copies start high to avoid false edges
  localparam link_state_t LINK_RST = '{
    prev_pins: '1,
    pins:      '1,
    oe_n:      '1,
    in_s1:     '1,
    in_s2:     '1,
    pos_s3:    '1,
    neg_s3:    '1,
    default:   '0
  };

  link_state_t l_reg, l_next;

  logic          tx_pop;
  logic          txq_valid;
  quad_word_t    txq_data;
  logic          rxq_ready;
  logic          rx_busy;
  logic          rx_en;
  logic [DW-1:0] beat_next;
  logic [DW-1:0] enc_data;
  logic [G-1:0]  enc_inv_n;
  logic [DW-1:0] dec_data;
  logic [G-1:0]  fall;

  lane_fifo #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .wclk    (clk),
    .wrst_n  (rst_n),
    .w_valid (tx_valid),
    .w_data  (tx_data),
    .w_ready (tx_ready),
    .rclk    (link_clk),
    .rrst_n  (lrst_n),
    .r_ready (tx_pop),
    .r_valid (txq_valid),
    .r_data  (txq_data)
  );

  lane_fifo #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .wclk    (link_clk),
    .wrst_n  (lrst_n),
    .w_valid (l_reg.rx_push),
    .w_data  (l_reg.rx_block),
    .w_ready (rxq_ready),
    .rclk    (clk),
    .rrst_n  (rst_n),
    .r_ready (rx_ready),
    .r_valid (rx_valid),
    .r_data  (rx_data)
  );

  // the far agent owns the lanes while its valid flag is seen and ours is quiet;
  // our own echo is masked until the synchronisers have flushed it
  assign rx_busy = !l_reg.in_s2.data_valid_flag_n && (l_reg.drv_hist == 3'h0);
  assign rx_en   = rx_busy && !l_reg.driving;

  // [RL11] idle clock when nothing queued
  assign tx_pop = (l_reg.phase == `PHASE_LAST) && l_reg.en_s2 && txq_valid && !rx_busy;

  assign beat_next = (l_reg.phase == `PHASE_LAST) ? txq_data[0]
                                                  : l_reg.block[l_reg.phase + 2'h1];

  genvar g;
  generate
    for (g = 0; g < G; g++) begin : g_grp
      logic [GW-1:0] plain;
      logic [GW-1:0] toggles;
      assign plain   = ~beat_next[g*GW +: GW];
      assign toggles = plain ^ l_reg.prev_pins[g*GW +: GW];
      // [RL10] inversion decision per group
      assign enc_inv_n[g] = !($countones(toggles) > `DBI_LIMIT);
      // [RL6] group data follows its own line
      assign enc_data[g*GW +: GW] = enc_inv_n[g] ? plain : beat_next[g*GW +: GW];
      // [RL7] active-high sense when inverted
      assign dec_data[g*GW +: GW] = l_reg.in_s2.group_polarity_invert_n[g]
                                  ? ~l_reg.in_s2.data[g*GW +: GW]
                                  : l_reg.in_s2.data[g*GW +: GW];
      // [RL5] each group uses its own strobe pair
      assign fall[g] = (l_reg.pos_s3[g] & ~l_reg.in_s2.data_strobe_pos_n[g])
                     | (l_reg.neg_s3[g] & ~l_reg.in_s2.data_strobe_neg_n[g]);
    end
  endgenerate

  always_comb begin
    l_next = l_reg;
    l_next.en_s1 = tx_enable;
    l_next.en_s2 = l_reg.en_s1;
    l_next.in_s1 = pins_in;
    l_next.in_s2 = l_reg.in_s1;
    l_next.pos_s3 = l_reg.in_s2.data_strobe_pos_n;
    l_next.neg_s3 = l_reg.in_s2.data_strobe_neg_n;
    // [RL9] one common clock is four link beats
    l_next.phase = l_reg.phase + 2'h1;
    l_next.drv_hist = {l_reg.drv_hist[1:0], l_reg.driving};
    l_next.rx_push = 1'b0;

    // [RL3] ownership decided once per common clock
    if (l_reg.phase == `PHASE_LAST) begin
      l_next.driving = tx_pop;
      if (tx_pop) begin
        l_next.block = txq_data;
      end
    end

    if (l_next.driving) begin
      // [RL1] whole data path driven together
      l_next.pins.data = enc_data;
      l_next.pins.group_polarity_invert_n = enc_inv_n;
      // [RL4] positive strobe falls on even beats
      l_next.pins.data_strobe_pos_n = {G{l_next.phase[0]}};
      l_next.pins.data_strobe_neg_n = {G{~l_next.phase[0]}};
      // [RL2] valid flag with every beat
      l_next.pins.data_valid_flag_n = 1'b0;
      // [RL12] strobes and inversion follow data ownership
      l_next.oe_n = '0;
      l_next.prev_pins = enc_data;
    end else begin
      l_next.pins = '1;
      l_next.oe_n = '1;
      l_next.prev_pins = '1;
    end

    if (rx_en) begin
      // [RL4] capture on either strobe edge
      for (int k = 0; k < G; k++) begin
        if (fall[k]) begin
          l_next.rx_block[l_reg.rx_cnt][k*GW +: GW] = dec_data[k*GW +: GW];
        end
      end
      if (fall[0]) begin
        l_next.rx_cnt = l_reg.rx_cnt + 2'h1;
        // a block that finds the queue full is dropped, the bus cannot stall
        if (l_reg.rx_cnt == `PHASE_LAST) begin
          l_next.rx_push = rxq_ready;
        end
      end
    end else if (l_reg.in_s2.data_valid_flag_n) begin
      // [RL11] idle clocks realign beat count
      l_next.rx_cnt = `PHASE_FIRST;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      l_reg <= LINK_RST;
    end else begin
      l_reg <= l_next;
    end
  end

  assign pins_out  = l_reg.pins;
  assign pins_oe_n = l_reg.oe_n;

  // ---------------- checks ----------------
  a_quad_beats: assert property ( // [RL3]
    @(posedge link_clk) disable iff (!lrst_n)
    $rose(l_reg.driving) |-> (l_reg.phase == 2'h0) ##0 l_reg.driving [*4]
  ) else $error("transfer did not last four beats");

  a_valid_marks: assert property ( // [RL2]
    @(posedge link_clk) disable iff (!lrst_n)
    (l_reg.oe_n.data != 4'hf) |-> !l_reg.pins.data_valid_flag_n
  ) else $error("data driven without valid flag");

  a_full_width: assert property ( // [RL1]
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.driving |-> (l_reg.oe_n.data == 4'h0)
  ) else $error("data path only partly driven");

  a_strobe_phase: assert property ( // [RL4]
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.driving |-> (l_reg.pins.data_strobe_pos_n == {G{l_reg.phase[0]}})
                   && (l_reg.pins.data_strobe_neg_n == {G{~l_reg.phase[0]}})
  ) else $error("strobe pattern out of step with beat");

  a_group_owner: assert property ( // [RL12]
    @(posedge link_clk) disable iff (!lrst_n)
    (l_reg.oe_n.strobe == l_reg.oe_n.data) && (l_reg.oe_n.inv == l_reg.oe_n.data)
  ) else $error("strobe or inversion driven apart from data");

  a_toggle_limit: assert property ( // [RL10]
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.driving && $past(l_reg.driving)
      |-> $countones(l_reg.pins.data[15:0] ^ $past(l_reg.pins.data[15:0])) <= 8
  ) else $error("group 0 toggled more than half its lines");

  a_inv_sense: assert property ( // [RL7]
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.driving |-> l_reg.pins.data[15:0] == (l_reg.pins.group_polarity_invert_n[0]
                    ? ~l_reg.block[l_reg.phase][15:0] : l_reg.block[l_reg.phase][15:0])
  ) else $error("group 0 polarity does not match its inversion line");

  a_group_map: assert property ( // [RL6]
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.driving |-> l_reg.pins.data[63:48] == (l_reg.pins.group_polarity_invert_n[3]
                    ? ~l_reg.block[l_reg.phase][63:48] : l_reg.block[l_reg.phase][63:48])
  ) else $error("group 3 not tied to inversion line 3");

  a_idle_clock: assert property ( // [RL11]
    @(posedge link_clk) disable iff (!lrst_n)
    (l_reg.phase == 2'h3) && !tx_pop |=> l_reg.pins.data_valid_flag_n [*4]
  ) else $error("valid flag active in an idle common clock");

  a_rx_block: assert property ( // [RL3]
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.rx_push |-> ($past(l_reg.rx_cnt) == 2'h3) && (l_reg.rx_cnt == 2'h0)
  ) else $error("received block pushed before its fourth beat");

  a_freq_fixed: assert property ( // [RL8]
    @(posedge clk) disable iff (!rst_n)
    ##1 $stable(bus_freq_select) && (bus_freq_select == FREQ_SEL)
  ) else $error("frequency select moved");

  c_back_to_back: cover property (
    @(posedge link_clk) disable iff (!lrst_n)
    (l_reg.phase == 2'h3) && l_reg.driving && tx_pop
  );

  c_inverted: cover property (
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.driving && (l_reg.pins.group_polarity_invert_n != 4'hf)
  );

  c_rx_block: cover property (
    @(posedge link_clk) disable iff (!lrst_n)
    l_reg.rx_push
  );

  c_rx_drop: cover property (
    @(posedge link_clk) disable iff (!lrst_n)
    rx_en && fall[0] && (l_reg.rx_cnt == 2'h3) && !rxq_ready
  );
endmodule

// *** shared/quad_lanes_map.svh ***
// macro constants for the quad-pumped data lanes
`ifndef QUAD_LANES_MAP_SVH
`define QUAD_LANES_MAP_SVH
`define DATA_WIDTH       64
`define LANE_GROUPS      4
`define GROUP_WIDTH      16
`define QUAD_BEATS       4
`define FIFO_DEPTH       8
`define DBI_LIMIT        8
`define PHASE_FIRST      2'h0
`define PHASE_LAST       2'h3
`define FREQ_SEL_WIDTH   3
`define FREQ_SEL_DEFAULT 3'h0
`endif

// *** shared/quad_lanes_pkg.sv ***
// shared types for the quad-pumped data lanes
`include "quad_lanes_map.svh"
package quad_lanes_pkg;
  // entry 0 is the first beat on the wire
  typedef logic [`QUAD_BEATS-1:0][`DATA_WIDTH-1:0] quad_word_t;

  // pin levels as seen on the wire, active low except data of groups whose inversion line is active
  typedef struct packed {
    logic [`DATA_WIDTH-1:0]  data;
    logic [`LANE_GROUPS-1:0] group_polarity_invert_n;
    logic [`LANE_GROUPS-1:0] data_strobe_pos_n;
    logic [`LANE_GROUPS-1:0] data_strobe_neg_n;
    logic                    data_valid_flag_n;
  } lane_pins_t;

  // output enables, low while driving; data is one enable per 16-bit group
  typedef struct packed {
    logic [`LANE_GROUPS-1:0] data;
    logic [`LANE_GROUPS-1:0] inv;
    logic [`LANE_GROUPS-1:0] strobe;
    logic                    valid;
  } lane_oe_t;
endpackage

// *** tb/far_agent.sv ***
// far-side agent model: sends and captures quad-pumped beats
`timescale 1ns/1ps
module far_agent (
  input  wire logic                       link_clk,
  input  wire quad_lanes_pkg::lane_pins_t lv,
  input  wire logic                       dut_drv,
  output quad_lanes_pkg::lane_pins_t      far_pins,
  output logic                            far_en
);
  import quad_lanes_pkg::*;
  quad_word_t  got_q[$];
  quad_word_t  cur;
  logic [63:0] prev = '1;
  logic [1:0]  cnt = 2'h0;
  int          dbi_err = 0, strobe_err = 0, inv_seen = 0, run = 0, max_run = 0;
  initial begin
    far_pins = '1;
    far_en = 1'b0;
  end
  // check and decode beats
  // sampled mid-cycle so pin updates at the rising edge have settled
  always @(negedge link_clk) begin
    if (dut_drv && !lv.data_valid_flag_n) begin
      if (lv.data_strobe_pos_n !== {4{cnt[0]}} || lv.data_strobe_neg_n !== {4{~cnt[0]}})
        strobe_err++;
      for (int g = 0; g < 4; g++) begin
        if ($countones(lv.data[16*g+:16] ^ prev[16*g+:16]) > 8) dbi_err++;
        if (!lv.group_polarity_invert_n[g]) inv_seen++;
        cur[cnt][16*g+:16] = lv.data[16*g+:16] ^ {16{lv.group_polarity_invert_n[g]}};
      end
      if (cnt == 2'h3) got_q.push_back(cur);
      cnt++;
      run++;
      max_run = (run > max_run) ? run : max_run;
    end else begin
      cnt = 2'h0;
      run = 0;
    end
    prev = lv.data;
  end
  // beats with group inversion
  // n below four sends a broken quad; gap delays the answer
  task automatic send(input quad_word_t b, input int n, input int gap);
    logic [63:0] lvl, e;
    logic [3:0]  iv;
    logic        s;
    lvl = '1;
    repeat (gap) @(posedge link_clk);
    for (int k = 0; k < n; k++) begin
      @(posedge link_clk);
      e = ~b[k];
      iv = 4'hf;
      for (int g = 0; g < 4; g++)
        if ($countones(e[16*g+:16] ^ lvl[16*g+:16]) > 8) begin
          e[16*g+:16] = b[k][16*g+:16];
          iv[g] = 1'b0;
        end
      lvl = e;
      s = k[0];
      far_pins <= {e, iv, {4{s}}, {4{~s}}, 1'b0};
      far_en <= 1'b1;
    end
    @(posedge link_clk);
    far_en <= 1'b0;
    far_pins <= '1;
  endtask
endmodule

// *** tb/quad_lanes_tb_top.sv ***
// self-checking bench for the quad-pumped data lanes
`timescale 1ns/1ps
module quad_lanes_tb_top;
  import quad_lanes_pkg::*;
  localparam logic [2:0] FSEL = 3'h5;
  logic       clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic       tx_enable = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  logic       tx_ready, rx_valid, far_en;
  logic [2:0] bus_freq_select;
  quad_word_t tx_data = '0, rx_data;
  lane_pins_t pins_in, pins_out, far_pins;
  lane_oe_t   pins_oe_n;
  int         err_count = 0, n_compared = 0, cycles = 0;

  always #10 clk = ~clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // wire level: an enabled driver wins, otherwise the pull-up
  always_comb begin
    pins_in = far_en ? far_pins : '1;
    for (int g = 0; g < 4; g++) begin
      if (!pins_oe_n.data[g]) pins_in.data[16*g+:16] = pins_out.data[16*g+:16];
      if (!pins_oe_n.inv[g])
        pins_in.group_polarity_invert_n[g] = pins_out.group_polarity_invert_n[g];
      if (!pins_oe_n.strobe[g]) begin
        pins_in.data_strobe_pos_n[g] = pins_out.data_strobe_pos_n[g];
        pins_in.data_strobe_neg_n[g] = pins_out.data_strobe_neg_n[g];
      end
    end
    if (!pins_oe_n.valid) pins_in.data_valid_flag_n = pins_out.data_valid_flag_n;
  end

  quad_lanes #(.FREQ_SEL(FSEL), .FIFO_DEPTH(8)) DUT (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .tx_enable(tx_enable),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .bus_freq_select(bus_freq_select),
    .pins_in(pins_in), .pins_out(pins_out), .pins_oe_n(pins_oe_n)
  );

  far_agent far (.link_clk(link_clk), .lv(pins_in), .dut_drv(!pins_oe_n.valid),
                 .far_pins(far_pins), .far_en(far_en));

  task automatic chk(input string nm, input logic [255:0] exp, input logic [255:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang costs a mismatch; all tests need well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  function automatic quad_word_t mk(input int n);
    quad_word_t q;
    for (int k = 0; k < 4; k++)
      q[k] = {4{16'(n * 16'h1357 + k * 16'h00ff)}} ^ (k[0] ? 64'hffff_0000_ffff_0000 : 64'h0);
    return q;
  endfunction

  // holds the block up until an edge after which tx_ready reads high, or 200 cycles
  task automatic push(input quad_word_t b);
    int i;
    i = 0;
    tx_valid <= 1'b1;
    tx_data <= b;
    do begin
      @(posedge clk);
      i++;
    end while (tx_ready !== 1'b1 && i < 200);
    chk("tx taken", 1, tx_ready);
  endtask

  task automatic wait_got(input int n);
    int i;
    i = 0;
    while (far.got_q.size() < n && i < 2000) begin
      @(posedge clk);
      i++;
    end
    chk("blocks seen", n, far.got_q.size());
  endtask

  task automatic pop_check(input quad_word_t exp);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rx_valid !== 1'b1 && i < 500);
    chk("rx valid", 1, rx_valid);
    chk("rx quad", exp, rx_data);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask

  task automatic t_reset();
    repeat (6) @(posedge clk);
    chk("freq select", FSEL, bus_freq_select);
    chk("lanes released", 1, &pins_oe_n);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("freq select", FSEL, bus_freq_select);
    chk("tx ready", 1, tx_ready);
    $display("test reset done");
  endtask

  task automatic t_tx_one();
    quad_word_t b;
    b[0] = 64'h0;
    b[1] = '1;
    b[2] = 64'h0;
    b[3] = 64'h00ff_00ff_0fff_0001;
    tx_enable <= 1'b1;
    push(b);
    tx_valid <= 1'b0;
    wait_got(1);
    chk("tx quad", b, far.got_q[0]);
    chk("inverted groups", 5, far.inv_seen);
    chk("toggle limit", 0, far.dbi_err);
    chk("strobe phase", 0, far.strobe_err);
    $display("test tx_one done");
  endtask

  task automatic t_fill();
    quad_word_t exp[8];
    tx_enable <= 1'b0;
    far.got_q.delete();
    repeat (8) @(posedge clk);
    for (int n = 0; n < 8; n++) begin
      exp[n] = mk(n);
      push(exp[n]);
    end
    tx_valid <= 1'b0;
    repeat (2) @(posedge clk);
    chk("full refuses", 0, tx_ready);
    chk("lanes released", 1, &pins_oe_n);
    tx_enable <= 1'b1;
    wait_got(8);
    for (int n = 0; n < 8; n++)
      chk("tx order", exp[n], far.got_q[n]);
    chk("valid run", 1, far.max_run >= 8);
    chk("toggle limit", 0, far.dbi_err);
    chk("strobe phase", 0, far.strobe_err);
    $display("test fill done");
  endtask

  task automatic t_rx();
    tx_enable <= 1'b0;
    repeat (8) @(posedge clk);
    far.send(mk(9), 2, 0);
    far.send(mk(20), 4, 3);
    far.send(mk(21), 4, 0);
    pop_check(mk(20));
    pop_check(mk(21));
    repeat (20) @(posedge clk);
    chk("no extra block", 0, rx_valid);
    chk("lanes released", 1, &pins_oe_n);
    $display("test rx done");
  endtask

  // nine blocks into an eight-deep queue: the last one is lost, the rest kept
  task automatic t_rx_drop();
    for (int n = 0; n < 9; n++)
      far.send(mk(30 + n), 4, 0);
    for (int n = 0; n < 8; n++)
      pop_check(mk(30 + n));
    repeat (20) @(posedge clk);
    chk("dropped block", 0, rx_valid);
    $display("test rx_drop done");
  endtask

  initial begin
    t_reset();
    t_tx_one();
    t_fill();
    t_rx();
    t_rx_drop();
    wrap_up();
  end
endmodule
